// ### rtl/sbat_pkg.sv
// Package for the switch buffer admission threshold block.
// Assumes a single pclk domain and an APB slave with 32-bit data.
package sbat_pkg;
   // Register indices; the byte address is four times the index.
   localparam logic [15:0] SBAT_IDX_CFG   = 16'h1c00;
   localparam logic [15:0] SBAT_IDX_DROP  = 16'h1c01;
   localparam logic [15:0] SBAT_IDX_PAUSE = 16'h1c02;
   localparam logic [15:0] SBAT_IDX_RESUM = 16'h1c03;
   localparam logic [15:0] SBAT_IDX_FLOOD = 16'h1c04;
   localparam logic [15:0] SBAT_IDX_DCNT0 = 16'h1c05;
   // Configuration field positions.
   localparam int SBAT_CFG_TEST  = 6;
   localparam int SBAT_CFG_FIXPR = 5;
   localparam int SBAT_CFG_EGR_H = 4;
   localparam int SBAT_CFG_EGR_L = 2;
   localparam int SBAT_CFG_YEL   = 1;
   localparam int SBAT_CFG_RED   = 0;
   localparam logic [6:0] SBAT_CFG_RST = 7'h00;
   // Level reset values, low setting (upper byte) then high setting (lower byte).
   localparam logic [7:0] SBAT_DROP_LO_RST  = 8'h49;
   localparam logic [7:0] SBAT_DROP_HI_RST  = 8'h64;
   localparam logic [7:0] SBAT_PAUSE_LO_RST = 8'h21;
   localparam logic [7:0] SBAT_PAUSE_HI_RST = 8'h3c;
   localparam logic [7:0] SBAT_RES_LO_RST   = 8'h03;
   localparam logic [7:0] SBAT_RES_HI_RST   = 8'h07;
   localparam logic [7:0] SBAT_FLOOD_RST    = 8'h31;
   // A port counts as active at 36 buffers of 128 bytes.
   localparam logic [7:0] SBAT_ACTIVE_BUFS  = 8'h24;
   localparam int         SBAT_BUF_BYTES    = 128;
   localparam int         SBAT_PORTS        = 3;
   // Counter test pattern and saturation value.
   localparam logic [31:0] SBAT_TEST_PAT = 32'h07ff_fffc;
   localparam logic [31:0] SBAT_CNT_MAX  = 32'hffff_ffff;
   // Pause value carried by the resume frame.
   localparam logic [15:0] SBAT_RESUME_QUANTA = 16'h0001;
   // Packet colours from the ingress meter.
   localparam logic [1:0] SBAT_GREEN  = 2'h0;
   localparam logic [1:0] SBAT_YELLOW = 2'h1;
   localparam logic [1:0] SBAT_RED    = 2'h2;
   // Admission decision states, one-hot.
   typedef enum logic [2:0] {
      SBAT_IDLE   = 3'b001,
      SBAT_DECIDE = 3'b010,
      SBAT_DONE   = 3'b100
   } sbat_state_e;
endpackage

// ### rtl/sbat_top.sv
// Threshold, pause and policy logic of the shared packet buffer manager.
// Assumes the buffer manager reports per-port usage and a flood total,
// presents one admission request at a time, and supplies a random value.
//
// Register access over APB is this design's own decision.
`timescale 1ns/100ps

module sbat_top (
   input  wire logic                 pclk,
   input  wire logic                 presetn,
   input  wire logic                 psel,
   input  wire logic                 penable,
   input  wire logic                 pwrite,
   input  wire logic [17:0]          paddr,
   input  wire logic [31:0]          pwdata,
   output logic      [31:0]          prdata,
   output logic                      pready,
   output logic                      pslverr,
   input  wire logic [23:0]          port_bufs_used,
   input  wire logic [7:0]           flood_bufs_used,
   input  wire logic                 adm_req,
   input  wire logic [1:0]           adm_port,
   input  wire logic [7:0]           adm_bufs,
   input  wire logic [1:0]           adm_color,
   input  wire logic                 adm_flood,
   input  wire logic                 rand_drop,
   output logic                      adm_done,
   output logic                      adm_accept,
   output logic [2:0]                pause_req,
   output logic [2:0]                resume_req,
   output logic [15:0]               resume_quanta,
   output logic [2:0]                egress_pace_en,
   output logic                      fixed_prio_sched
);
   import sbat_pkg::*;

   // Stored configuration fields. Only documented bits have flops, so a
   // reserved bit cannot hold a value and always reads back as zero.
   logic [6:0]  cfg_reg;
   // Level pairs; the low setting serves two or three active ports.
   logic [7:0]  drop_lo_reg, drop_hi_reg;
   logic [7:0]  pause_lo_reg, pause_hi_reg;
   logic [7:0]  res_lo_reg, res_hi_reg;
   // Cap on the buffers held by flooded traffic.
   logic [7:0]  flood_reg;
   // Per-port drop counters, one word each, cleared by a read.
   logic [31:0] dcnt_reg [SBAT_PORTS];
   // Per-port paused flags used for pause/resume hysteresis.
   // Without them a pause frame would go out on every cycle above level.
   logic [2:0]  paused_reg;
   // Admission sequencer: state, stored verdict and captured port.
   // The port is captured so that a change of the port input between
   // request and decision cannot charge a drop to another port.
   sbat_state_e state_reg, state_next;
   logic        drop_reg;
   logic [1:0]  port_q_reg;

   // Usage of one port out of the packed vector, in 128-byte buffers.
   // Port p occupies byte p of the vector.
   function automatic logic [7:0] usage(input logic [23:0] v,
                                        input logic [1:0] p);
      usage = v[8*p +: 8];
   endfunction

   // Saturating increment so a counter never wraps.
   // Saturation keeps a long-running count from reading as a small one.
   function automatic logic [31:0] sat_inc(input logic [31:0] c);
      sat_inc = (c == SBAT_CNT_MAX) ? c : c + 32'h0000_0001;
   endfunction

   // APB decode; the word index sits above the two byte-lane bits.
   // The two low address bits are ignored: every register is one word.
   wire [15:0] widx     = paddr[17:2];
   // Access phase strobes, split by direction.
   wire        acc      = psel && penable;
   wire        wr       = acc && pwrite;
   wire        rd       = acc && !pwrite;
   // One select per register word.
   wire        hit_cfg  = widx == SBAT_IDX_CFG;
   wire        hit_drop = widx == SBAT_IDX_DROP;
   wire        hit_pau  = widx == SBAT_IDX_PAUSE;
   wire        hit_res  = widx == SBAT_IDX_RESUM;
   wire        hit_fld  = widx == SBAT_IDX_FLOOD;
   // The counters occupy the words right after the flood limit.
   wire [15:0] cnt_off  = widx - SBAT_IDX_DCNT0;
   wire        hit_cnt  = cnt_off < 16'(SBAT_PORTS);
   // Any other word answers with an error and reads as zero.
   wire        mapped   = hit_cfg | hit_drop | hit_pau | hit_res |
                          hit_fld | hit_cnt;

   // Active-port count; a port is active at the fixed buffer threshold.
   wire [2:0] act_vec;
   // One loop variable serves both per-port generate loops.
   genvar g;
   generate
      for (g = 0; g < SBAT_PORTS; g++) begin : g_act
         assign act_vec[g] = usage(port_bufs_used, 2'(g))
                             >= SBAT_ACTIVE_BUFS;
      end
   endgenerate
   // At most three ports are counted, so two bits hold the sum.
   wire [1:0] act_cnt = 2'(act_vec[0]) + 2'(act_vec[1]) + 2'(act_vec[2]);
   // Two or three active ports select the low settings. The count is
   // taken from live usage, so the levels follow the load every cycle.
   wire       use_low = act_cnt >= 2'h2;

   // Levels in force right now.
   wire [7:0] drop_lvl  = use_low ? drop_lo_reg  : drop_hi_reg;
   wire [7:0] pause_lvl = use_low ? pause_lo_reg : pause_hi_reg;
   wire [7:0] res_lvl   = use_low ? res_lo_reg   : res_hi_reg;

   // Admission decision for the request captured last cycle.
   // Sums carry one extra bit so a large packet cannot wrap to a small
   // total and slip under a level.
   wire [7:0] cur_use  = usage(port_bufs_used, port_q_reg);
   wire [8:0] new_use  = {1'b0, cur_use} + {1'b0, adm_bufs};
   wire [8:0] new_fld  = {1'b0, flood_bufs_used} + {1'b0, adm_bufs};
   wire       over_lvl = new_use > {1'b0, drop_lvl};
   wire       over_fld = adm_flood && (new_fld > {1'b0, flood_reg});
   wire       red_drop = cfg_reg[SBAT_CFG_RED] &&
                         (adm_color == SBAT_RED);
   wire       yel_drop = cfg_reg[SBAT_CFG_YEL] && rand_drop &&
                         (adm_color == SBAT_YELLOW);
   // Any one reason is enough to refuse the packet.
   wire       drop_now = over_lvl | over_fld | red_drop | yel_drop;

   // Read mux; reserved bits are zero-filled.
   // Unmapped words fall through to the zero default.
   logic [31:0] rd_mux;
   always_comb begin
      rd_mux = 32'h0000_0000;
      if (hit_cfg)
         rd_mux = {25'h0, cfg_reg};
      else if (hit_drop)
         rd_mux = {16'h0, drop_lo_reg, drop_hi_reg};
      else if (hit_pau)
         rd_mux = {16'h0, pause_lo_reg, pause_hi_reg};
      else if (hit_res)
         rd_mux = {16'h0, res_lo_reg, res_hi_reg};
      else if (hit_fld)
         rd_mux = {24'h0, flood_reg};
      else if (hit_cnt)
         rd_mux = dcnt_reg[cnt_off[1:0]];
   end

   // Next state of the admission sequencer.
   // A request is only taken in idle, so one decision runs at a time
   // and a request raised while busy is simply not seen.
   always_comb begin
      case (state_reg)
         SBAT_IDLE:   state_next = adm_req ? SBAT_DECIDE : SBAT_IDLE;
         SBAT_DECIDE: state_next = SBAT_DONE;
         SBAT_DONE:   state_next = SBAT_IDLE;
         default:     state_next = SBAT_IDLE;
      endcase
   end

   // APB answer: zero wait states, error on unmapped addresses.
   // Read data are latched in the setup cycle and held until the next
   // read, so they stand through the whole access phase.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata  <= 32'h0000_0000;
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready  <= psel && !penable;
         pslverr <= psel && !penable && !mapped;
         prdata  <= (psel && !penable && !pwrite) ? rd_mux : prdata;
      end
   end

   // Writable registers; only the documented field widths are stored.
   // A write lands at the edge that ends the access phase, never in setup.
   // Writes to counter words or unmapped words change nothing.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cfg_reg      <= SBAT_CFG_RST;
         drop_lo_reg  <= SBAT_DROP_LO_RST;
         drop_hi_reg  <= SBAT_DROP_HI_RST;
         pause_lo_reg <= SBAT_PAUSE_LO_RST;
         pause_hi_reg <= SBAT_PAUSE_HI_RST;
         res_lo_reg   <= SBAT_RES_LO_RST;
         res_hi_reg   <= SBAT_RES_HI_RST;
         flood_reg    <= SBAT_FLOOD_RST;
      end else if (wr && pready) begin
         if (hit_cfg)
            cfg_reg <= pwdata[6:0];
         if (hit_drop) begin
            drop_lo_reg <= pwdata[15:8];
            drop_hi_reg <= pwdata[7:0];
         end
         if (hit_pau) begin
            pause_lo_reg <= pwdata[15:8];
            pause_hi_reg <= pwdata[7:0];
         end
         if (hit_res) begin
            res_lo_reg <= pwdata[15:8];
            res_hi_reg <= pwdata[7:0];
         end
         if (hit_fld)
            flood_reg <= pwdata[7:0];
      end
   end

   // Drop counters. A drop in the access cycle of a read is honoured:
   // the read returns the old value and the counter restarts at one,
   // but a drop counted at the end of the setup cycle is lost to the clear.
   // In counter test mode a read loads the test pattern instead of zero.
   // The counters have no write path; a bus write to them is ignored.
   generate
      for (g = 0; g < SBAT_PORTS; g++) begin : g_cnt
         wire rd_hit = rd && pready && hit_cnt && (cnt_off[1:0] == 2'(g));
         wire inc    = (state_reg == SBAT_DONE) && drop_reg &&
                       (port_q_reg == 2'(g));
         wire [31:0] base = !rd_hit ? dcnt_reg[g] :
                            cfg_reg[SBAT_CFG_TEST] ? SBAT_TEST_PAT
                                                   : 32'h0000_0000;
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn)
               dcnt_reg[g] <= 32'h0000_0000;
            else
               dcnt_reg[g] <= inc ? sat_inc(base) : base;
         end
      end
   endgenerate

   // Admission sequencer: capture, decide, then publish the verdict.
   // The verdict is registered so the outputs come from flops; the
   // price is a fixed two-cycle latency from request to answer.
   // The drop counter of the captured port counts one cycle later.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_reg  <= SBAT_IDLE;
         port_q_reg <= 2'h0;
         drop_reg   <= 1'b0;
         adm_done   <= 1'b0;
         adm_accept <= 1'b0;
      end else begin
         state_reg <= state_next;
         if (state_reg == SBAT_IDLE && adm_req)
            port_q_reg <= adm_port;
         if (state_reg == SBAT_DECIDE)
            drop_reg <= drop_now;
         adm_done   <= state_reg == SBAT_DECIDE;
         adm_accept <= (state_reg == SBAT_DECIDE) && !drop_now;
      end
   end

   // Pause/resume hysteresis per port. A pause request fires once when
   // usage reaches the pause level; the resume frame fires once when it
   // falls to the resume level, so frames are not sent every cycle.
   // Level compares per port against the settings now in force.
   logic [2:0] pause_hit, res_hit;
   always_comb begin
      for (int p = 0; p < SBAT_PORTS; p++) begin
         pause_hit[p] = usage(port_bufs_used, 2'(p)) >= pause_lvl;
         res_hit[p]   = usage(port_bufs_used, 2'(p)) <= res_lvl;
      end
   end

   // A port at or above its pause level never gets a resume pulse.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         paused_reg <= 3'h0;
         pause_req  <= 3'h0;
         resume_req <= 3'h0;
      end else begin
         pause_req  <= ~paused_reg & pause_hit;
         resume_req <= paused_reg & res_hit & ~pause_hit;
         paused_reg <= (paused_reg | pause_hit) & ~(res_hit & ~pause_hit);
      end
   end

   // Policy outputs to the scheduler and pacers.
   // These trail the configuration register by one cycle.
   // The resume frame always carries a pause value of one.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         egress_pace_en   <= 3'h0;
         fixed_prio_sched <= 1'b0;
         resume_quanta    <= 16'h0000;
      end else begin
         egress_pace_en   <= cfg_reg[SBAT_CFG_EGR_H:SBAT_CFG_EGR_L];
         fixed_prio_sched <= cfg_reg[SBAT_CFG_FIXPR];
         resume_quanta    <= SBAT_RESUME_QUANTA;
      end
   end
endmodule

// ### verification/sbat_properties.sv
// Port checks for the buffer admission threshold block.
// Assumes one pclk domain; bound to sbat_top below.
`timescale 1ns/100ps
module sbat_props (
   input logic        pclk,
   input logic        presetn,
   input logic        psel,
   input logic        penable,
   input logic        pwrite,
   input logic [17:0] paddr,
   input logic [31:0] pwdata,
   input logic [31:0] prdata,
   input logic        pready,
   input logic        pslverr,
   input logic        adm_req,
   input logic        adm_done,
   input logic        adm_accept,
   input logic [2:0]  pause_req,
   input logic [2:0]  resume_req,
   input logic [15:0] resume_quanta,
   input logic [2:0]  egress_pace_en,
   input logic        fixed_prio_sched
);
   import sbat_pkg::*;
   // Byte address of the configuration word.
   localparam logic [17:0] CFG_A = {SBAT_IDX_CFG, 2'b00};
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   a_apb_answer: assert property (psel && !penable |=> pready)
      else $error("setup not answered next cycle");
   a_unmapped_zero: assert property (
      pready && pslverr && !pwrite |-> prdata == 32'h0)
      else $error("unmapped read gave data");
   a_cfg_reserved: assert property (
      pready && !pwrite && paddr == CFG_A |-> prdata[31:7] == 25'h0)
      else $error("reserved config bits read nonzero");
   // The pacing and priority outputs trail a config write by two cycles.
   a_egress_follow: assert property (
      psel && penable && pready && pwrite && paddr == CFG_A |->
      ##2 egress_pace_en == $past(pwdata[4:2], 2))
      else $error("pacing enables do not follow write");
   a_prio_follow: assert property (
      psel && penable && pready && pwrite && paddr == CFG_A |->
      ##2 fixed_prio_sched == $past(pwdata[5], 2))
      else $error("priority mode does not follow write");
   a_quanta_one: assert property (
      $past(presetn) |-> resume_quanta == SBAT_RESUME_QUANTA)
      else $error("resume value is not one");
   a_adm_latency: assert property (adm_done |-> $past(adm_req, 2))
      else $error("decision without request two cycles before");
   a_adm_pulse: assert property (adm_done |=> !adm_done [*2])
      else $error("decision pulse too long");
   a_flow_excl: assert property ((pause_req & resume_req) == 3'b000)
      else $error("pause and resume on one port together");
   c_drop: cover property (adm_done && !adm_accept);
   c_pause: cover property (pause_req != 3'b000);
   c_resume: cover property (resume_req != 3'b000);
endmodule

bind sbat_top sbat_props u_props (.pclk, .presetn, .psel, .penable,
   .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .adm_req,
   .adm_done, .adm_accept, .pause_req, .resume_req, .resume_quanta,
   .egress_pace_en, .fixed_prio_sched);

// ### verification/tb_top.sv
// Self-checking bench for the buffer admission threshold block.
// Assumes sbat_pkg is compiled first; drives all ports itself.
`timescale 1ns/100ps
module tb_top;
   import sbat_pkg::*;
   logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0;
   logic        penable = 1'b0, pwrite = 1'b0, adm_req = 1'b0;
   logic        adm_flood = 1'b0, rand_drop = 1'b0;
   logic [17:0] paddr = 18'h0;
   logic [31:0] pwdata = 32'h0;
   logic [23:0] port_bufs_used = 24'h0;
   logic [7:0]  flood_bufs_used = 8'h28, adm_bufs = 8'h0;
   logic [1:0]  adm_port = 2'h0, adm_color = 2'h0;
   logic [31:0] prdata, q;
   logic [2:0]  pause_req, resume_req, egress_pace_en;
   logic [15:0] resume_quanta;
   logic        pready, pslverr, adm_done, adm_accept, fixed_prio_sched;
   logic        e, h;
   int          failures, comparisons, nd;
   logic [31:0] rstv [5] = '{32'h0, 32'h4964, 32'h213c, 32'h0307, 32'h31};
   logic [31:0] mask [5] = '{32'h7f, 32'hffff, 32'hffff, 32'hffff, 32'hff};
   sbat_top uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
      .pwdata, .prdata, .pready, .pslverr, .port_bufs_used,
      .flood_bufs_used, .adm_req, .adm_port, .adm_bufs, .adm_color,
      .adm_flood, .rand_drop, .adm_done, .adm_accept, .pause_req,
      .resume_req, .resume_quanta, .egress_pace_en, .fixed_prio_sched);
   // Free-running 4 ns clock.
   initial begin
      forever #2 pclk = ~pclk;
   end
   task chk(input string n, input logic [31:0] x, input logic [31:0] g);
      comparisons++;
      if (g !== x) begin
         failures++;
         $display("BAD %s exp %h got %h", n, x, g);
      end
   endtask
   // One APB transfer; the request is held until pready is sampled high.
   task apb(input logic w, input logic [15:0] i, input logic [31:0] d);
      int k;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= {i, 2'b00};
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      for (k = 0; k < 20; k++) begin
         @(posedge pclk);
         if (pready === 1'b1) break;
      end
      if (k == 20) failures++;
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task rdc(input logic [15:0] i, input logic [31:0] x);
      apb(1'b0, i, 32'h0);
      chk("prdata", x, q);
   endtask
   // Admission on the port in adm_port; adm_req is a one-cycle pulse, the other inputs stay put until the answer.
   task adm(input logic [23:0] u, input logic [7:0] b, input logic [1:0] c,
            input logic f, input logic r, input logic x);
      int k;
      @(posedge pclk);
      adm_req <= 1'b1;
      port_bufs_used <= u;
      adm_bufs <= b;
      adm_color <= c;
      adm_flood <= f;
      rand_drop <= r;
      @(posedge pclk);
      adm_req <= 1'b0;
      for (k = 0; k < 8; k++) begin
         @(posedge pclk);
         if (adm_done === 1'b1) break;
      end
      chk("adm_done", 32'h1, {31'h0, adm_done});
      chk("adm_accept", {31'h0, x}, {31'h0, adm_accept});
      if (!x) nd++;
   endtask
   // Sets usage and watches port 2 for a pause or resume pulse.
   task flow(input logic [23:0] u, input logic r, input logic x);
      @(posedge pclk);
      port_bufs_used <= u;
      h = 1'b0;
      repeat (6) begin
         @(posedge pclk);
         if ((r ? resume_req[2] : pause_req[2]) === 1'b1) h = 1'b1;
      end
      chk("flow_req", {31'h0, x}, {31'h0, h});
   endtask
   task test_done;
      $display("failures %0d comparisons %0d", failures, comparisons);
      if (failures == 0 && comparisons > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   // Generous bound; the sequence needs well under a thousand cycles.
   initial begin
      repeat (5000) @(posedge pclk);
      failures++;
      test_done;
   end
   initial begin
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      for (int i = 0; i < 5; i++) begin
         rdc(SBAT_IDX_CFG + 16'(i), rstv[i]);
      end
      rdc(SBAT_IDX_DCNT0, 32'h0);
      for (int i = 0; i < 5; i++) begin
         apb(1'b1, SBAT_IDX_CFG + 16'(i), 32'hffff_ffff);
         rdc(SBAT_IDX_CFG + 16'(i), mask[i]);
         apb(1'b1, SBAT_IDX_CFG + 16'(i), rstv[i]);
      end
      apb(1'b1, SBAT_IDX_DCNT0, 32'h1234);
      rdc(SBAT_IDX_DCNT0, 32'h0);
      apb(1'b0, 16'h1c08, 32'h0);
      chk("pslverr", 32'h1, {31'h0, e});
      chk("prdata", 32'h0, q);
      for (int j = 0; j < 2; j++) begin
         apb(1'b1, SBAT_IDX_CFG, j ? 32'h0 : 32'h34);
         repeat (2) @(posedge pclk);
         #1;
         chk("egress", j ? 32'h0 : 32'h5, {29'h0, egress_pace_en});
         chk("prio", j ? 32'h0 : 32'h1, {31'h0, fixed_prio_sched});
      end
      adm(24'h000028, 8'h3c, SBAT_GREEN, 1'b0, 1'b0, 1'b1);
      adm(24'h000028, 8'h3d, SBAT_GREEN, 1'b0, 1'b0, 1'b0);
      adm(24'h002328, 8'h3c, SBAT_GREEN, 1'b0, 1'b0, 1'b1);
      adm(24'h002428, 8'h21, SBAT_GREEN, 1'b0, 1'b0, 1'b1);
      adm(24'h002428, 8'h22, SBAT_GREEN, 1'b0, 1'b0, 1'b0);
      adm(24'h0, 8'h09, SBAT_GREEN, 1'b1, 1'b0, 1'b1);
      adm(24'h0, 8'h0a, SBAT_GREEN, 1'b1, 1'b0, 1'b0);
      adm(24'h0, 8'h01, SBAT_RED, 1'b0, 1'b0, 1'b1);
      adm(24'h0, 8'h01, SBAT_YELLOW, 1'b0, 1'b1, 1'b1);
      apb(1'b1, SBAT_IDX_CFG, 32'h3);
      adm(24'h0, 8'h01, SBAT_RED, 1'b0, 1'b0, 1'b0);
      adm(24'h0, 8'h01, SBAT_YELLOW, 1'b0, 1'b1, 1'b0);
      adm(24'h0, 8'h01, SBAT_YELLOW, 1'b0, 1'b0, 1'b1);
      rdc(SBAT_IDX_DCNT0, 32'(nd));
      rdc(SBAT_IDX_DCNT0, 32'h0);
      // A drop on port 2 must land in the third counter only.
      adm_port <= 2'h2;
      adm(24'h280000, 8'h3d, SBAT_GREEN, 1'b0, 1'b0, 1'b0);
      rdc(SBAT_IDX_DCNT0 + 16'h0002, 32'h0000_0001);
      apb(1'b1, SBAT_IDX_CFG, 32'h40);
      rdc(SBAT_IDX_DCNT0, 32'h0);
      rdc(SBAT_IDX_DCNT0, 32'h07ff_fffc);
      flow(24'h3c0000, 1'b0, 1'b1);
      flow(24'h070000, 1'b1, 1'b1);
      chk("quanta", 32'h1, {16'h0, resume_quanta});
      flow(24'h202828, 1'b0, 1'b0);
      flow(24'h212828, 1'b0, 1'b1);
      flow(24'h042828, 1'b1, 1'b0);
      flow(24'h032828, 1'b1, 1'b1);
      test_done;
   end
endmodule
